// >>> opc_consts.vh
/*
 * register offsets, field positions and reset values of the output and power
 * control register group. assumes inclusion by bare name from design files.
 */
`ifndef OPC_CONSTS_VH
`define OPC_CONSTS_VH

// register addresses on the control port
`define OPC_ADDR_PWR 8'h1e
`define OPC_ADDR_OSEL1 8'h1f
`define OPC_ADDR_OSEL2 8'h20
`define OPC_ADDR_RSVA 8'h21
`define OPC_ADDR_RSVB 8'h22

// reset values
`define OPC_RST_PWR 8'h30
`define OPC_RST_OSEL1 8'h94
`define OPC_RST_OSEL2 8'h05
`define OPC_RST_RSVA 8'h20
`define OPC_RST_RSVB 8'h32

// power control fields
`define OPC_PWR_AUTO 4
`define OPC_PWR_DOWN 3
`define OPC_PWR_PINPOL 2
`define OPC_PWR_FAST 1
`define OPC_PWR_SOGZ 0

// output select one fields
`define OPC_OS1_MODE_HI 7
`define OPC_OS1_MODE_LO 5
`define OPC_OS1_PRI_EN 4
`define OPC_OS1_SEC_EN 3
`define OPC_OS1_DRV_HI 2
`define OPC_OS1_DRV_LO 1
`define OPC_OS1_CLKINV 0

// output select two fields
`define OPC_OS2_CLK_HI 7
`define OPC_OS2_CLK_LO 6
`define OPC_OS2_ALLZ 5
`define OPC_OS2_SOGZ 4
`define OPC_OS2_FPOL 3
`define OPC_OS2_PLLFILT 2
`define OPC_OS2_SPFILT 1

// encodings
`define OPC_MODE_444 3'h4
`define OPC_MODE_422 3'h5
`define OPC_MODE_DDR 3'h6
`define OPC_DRV_LOW 2'h0
`define OPC_DRV_MED 2'h1
`define OPC_DRV_HIGH 2'h2
`define OPC_CLK_PIX 2'h0
`define OPC_CLK_P90 2'h1
`define OPC_CLK_X2 2'h2
`define OPC_CLK_HALF 2'h3

`endif

// >>> opc_pin_sync.v
/*
 * three-stage synchroniser for the power-down pin. a change is taken once the
 * second and third stages agree. assumes one system clock, synchronous reset.
 */
`include "opc_consts.vh"

module opc_pin_sync (
	// clock and reset
	input wire sys_clk_in,
	input wire sys_rst_in,
	// async level in, filtered level out
	input wire pin_in,
	output reg level_out
);

	reg s1_q;
	reg s2_q;
	reg s3_q;

	// s1 feeds only s2: metastability guard
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
		end
	end

endmodule // opc_pin_sync

// >>> opc_output_power_regs.v
/*
 * output and power control register group: byte-wide register port as the
 * documented serial control port delivers it (address, data, write strobe,
 * read data), decoded controls for the pixel output stage, clock generator
 * and sync processor. assumes the serial port decoder lives outside and
 * presents one-cycle write strobes on sys_clk_in.
 */
`include "opc_consts.vh"

// Overview of operation
// - power control bit 3 set forces power-down; cleared is normal operation
// - power control bit 2 picks power-down pin level: 0 low, 1 high
// - power control bit 1 turns power-down into outputs-tristate, chip stays powered
// - power control bit 0 tristates green sync output during power-down
// - output select one bits 7:5 choose 4:4:4, 4:2:2 or DDR 4:4:4
// - output select one bit 4 enables primary port, else high impedance
// - output select one bit 3 enables secondary port, else high impedance
// - bits 2:1 pick drive low, medium, high; not for vertical sync output
// - output select one bit 0 inverts pixel clock output
// - output select two bits 7:6 choose pixel, 90 degree, double, half clock
// - output select two bit 5 tristates all outputs but green sync output
// - output select two bit 4 tristates green sync output
// - output select two bit 3 swaps field output polarity
// - output select two bit 2 feeds clock generator filtered sync
// - output select two bit 1 feeds sync processor regenerated sync
// - power control bit 4 selects automatic power-down control
module opc_output_power_regs (
	// clock and reset
	input wire sys_clk_in,
	input wire sys_rst_in,
	// register port
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	output reg [7:0] reg_rdata_out,
	// power-down pin and automatic power-down request
	input wire pwrdn_pin_in,
	input wire auto_idle_in,
	// pipeline sources
	input wire pix_clk_in,
	input wire pix_clk_p90_in,
	input wire pix_clk_x2_in,
	input wire pix_clk_half_in,
	input wire field_odd_in,
	input wire raw_sync_in,
	input wire filt_sync_in,
	input wire regen_sync_in,
	// decoded controls
	output reg power_down_out,
	output reg [2:0] out_mode_out,
	output reg mode_444_out,
	output reg mode_422_out,
	output reg mode_ddr_out,
	output reg [1:0] drive_level_out,
	output reg [1:0] vsync_drive_out,
	output reg pixel_clock_out_pin_out,
	output reg field_out,
	output reg clkgen_sync_out,
	output reg syncproc_sync_out,
	// pin output enables
	output reg primary_oe_out,
	output reg secondary_oe_out,
	output reg pixel_clock_oe_out,
	output reg vertical_sync_oe_out,
	output reg ctrl_pins_oe_out,
	output reg green_sync_out_pin_oe_out
);

	reg [7:0] pwr_q;
	reg [7:0] os1_q;
	reg [7:0] os2_q;
	reg [7:0] rsva_q;
	reg [7:0] rsvb_q;
	wire pin_lvl;
	reg pin_req;
	reg pd_req;
	reg pd_full;
	reg pd_fast;
	reg allz;
	reg sogz;
	reg clk_sel;
	reg [1:0] drv;

	opc_pin_sync u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.pin_in(pwrdn_pin_in),
		.level_out(pin_lvl)
	);

	// register writes; bit 0 of output select two is written as given,
	// software must keep it at one
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pwr_q <= `OPC_RST_PWR;
			os1_q <= `OPC_RST_OSEL1;
			os2_q <= `OPC_RST_OSEL2;
			rsva_q <= `OPC_RST_RSVA;
			rsvb_q <= `OPC_RST_RSVB;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `OPC_ADDR_PWR) begin
				pwr_q <= reg_wdata_in;
			end else if (reg_addr_in == `OPC_ADDR_OSEL1) begin
				os1_q <= reg_wdata_in;
			end else if (reg_addr_in == `OPC_ADDR_OSEL2) begin
				os2_q <= reg_wdata_in;
			end else if (reg_addr_in == `OPC_ADDR_RSVA) begin
				rsva_q <= reg_wdata_in;
			end else if (reg_addr_in == `OPC_ADDR_RSVB) begin
				rsvb_q <= reg_wdata_in;
			end
		end
	end

	// combinational power-down request
	always @* begin
		// pin polarity: 0 active low, 1 active high
		pin_req = pwr_q[`OPC_PWR_PINPOL] ? pin_lvl : ~pin_lvl;
		// automatic mode takes the idle request and the pin, manual mode the pin only
		if (pwr_q[`OPC_PWR_AUTO]) begin
			pd_req = pwr_q[`OPC_PWR_DOWN] | auto_idle_in | pin_req;
		end else begin
			pd_req = pwr_q[`OPC_PWR_DOWN] | pin_req;
		end
		// fast switching keeps the core up, only tristates
		pd_full = pd_req & ~pwr_q[`OPC_PWR_FAST];
		pd_fast = pd_req;
		allz = os2_q[`OPC_OS2_ALLZ] | pd_fast;
		sogz = os2_q[`OPC_OS2_SOGZ] | (pd_fast & pwr_q[`OPC_PWR_SOGZ]);
		// upper two drive codes both mean high
		if (os1_q[`OPC_OS1_DRV_HI:`OPC_OS1_DRV_LO] == `OPC_DRV_LOW) begin
			drv = `OPC_DRV_LOW;
		end else if (os1_q[`OPC_OS1_DRV_HI:`OPC_OS1_DRV_LO] == `OPC_DRV_MED) begin
			drv = `OPC_DRV_MED;
		end else begin
			drv = `OPC_DRV_HIGH;
		end
		case (os2_q[`OPC_OS2_CLK_HI:`OPC_OS2_CLK_LO])
			`OPC_CLK_PIX: clk_sel = pix_clk_in;
			`OPC_CLK_P90: clk_sel = pix_clk_p90_in;
			`OPC_CLK_X2: clk_sel = pix_clk_x2_in;
			default: clk_sel = pix_clk_half_in;
		endcase
	end

	// registered outputs; clock path is sampled too, so this models the
	// selection only, not a glitch-free analog clock mux
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			power_down_out <= 1'b0;
			out_mode_out <= `OPC_MODE_444;
			mode_444_out <= 1'b1;
			mode_422_out <= 1'b0;
			mode_ddr_out <= 1'b0;
			drive_level_out <= `OPC_DRV_HIGH;
			vsync_drive_out <= `OPC_DRV_HIGH;
			pixel_clock_out_pin_out <= 1'b0;
			field_out <= 1'b0;
			clkgen_sync_out <= 1'b0;
			syncproc_sync_out <= 1'b0;
			primary_oe_out <= 1'b0;
			secondary_oe_out <= 1'b0;
			pixel_clock_oe_out <= 1'b0;
			vertical_sync_oe_out <= 1'b0;
			ctrl_pins_oe_out <= 1'b0;
			green_sync_out_pin_oe_out <= 1'b0;
			reg_rdata_out <= 8'h00;
		end else begin
			power_down_out <= pd_full;
			out_mode_out <= os1_q[`OPC_OS1_MODE_HI:`OPC_OS1_MODE_LO];
			mode_444_out <= (os1_q[`OPC_OS1_MODE_HI:`OPC_OS1_MODE_LO] == `OPC_MODE_444);
			mode_422_out <= (os1_q[`OPC_OS1_MODE_HI:`OPC_OS1_MODE_LO] == `OPC_MODE_422);
			mode_ddr_out <= (os1_q[`OPC_OS1_MODE_HI:`OPC_OS1_MODE_LO] == `OPC_MODE_DDR);
			drive_level_out <= drv;
			// vertical sync output keeps a fixed drive
			vsync_drive_out <= `OPC_DRV_HIGH;
			pixel_clock_out_pin_out <= clk_sel ^ os1_q[`OPC_OS1_CLKINV];
			field_out <= field_odd_in ^ os2_q[`OPC_OS2_FPOL];
			clkgen_sync_out <= os2_q[`OPC_OS2_PLLFILT] ? filt_sync_in : raw_sync_in;
			syncproc_sync_out <= os2_q[`OPC_OS2_SPFILT] ? regen_sync_in : raw_sync_in;
			primary_oe_out <= os1_q[`OPC_OS1_PRI_EN] & ~allz;
			secondary_oe_out <= os1_q[`OPC_OS1_SEC_EN] & ~allz;
			pixel_clock_oe_out <= ~allz;
			vertical_sync_oe_out <= ~allz;
			ctrl_pins_oe_out <= ~allz;
			green_sync_out_pin_oe_out <= ~sogz;
			if (reg_addr_in == `OPC_ADDR_PWR) begin
				reg_rdata_out <= pwr_q;
			end else if (reg_addr_in == `OPC_ADDR_OSEL1) begin
				reg_rdata_out <= os1_q;
			end else if (reg_addr_in == `OPC_ADDR_OSEL2) begin
				reg_rdata_out <= os2_q;
			end else if (reg_addr_in == `OPC_ADDR_RSVA) begin
				reg_rdata_out <= rsva_q;
			end else if (reg_addr_in == `OPC_ADDR_RSVB) begin
				reg_rdata_out <= rsvb_q;
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

endmodule // opc_output_power_regs

// >>> opc_regs_assertions.sv
/* checker for the output and power register group.
   assumes it is bound onto opc_output_power_regs. */
module opc_regs_assertions (
	// clock, reset, register port
	input wire logic sys_clk_in, sys_rst_in, reg_wr_in,
	input wire logic [7:0] reg_addr_in, reg_wdata_in,
	// sources
	input wire logic field_odd_in, raw_sync_in, filt_sync_in,
	// decoded controls and enables
	input wire logic power_down_out, field_out, clkgen_sync_out,
	input wire logic [2:0] out_mode_out,
	input wire logic [1:0] drive_level_out,
	input wire logic primary_oe_out, secondary_oe_out, green_sync_out_pin_oe_out
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [2:0] up_q;
	wire w1 = reg_wr_in && reg_addr_in == 8'h1f;
	wire w2 = reg_wr_in && reg_addr_in == 8'h20;
	wire wp = reg_wr_in && reg_addr_in == 8'h1e;
	// settles after reset so $past never reaches into it
	always @(posedge sys_clk_in) up_q <= sys_rst_in ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	chk_mode_take: assert property (w1 |-> ##2 out_mode_out == $past(reg_wdata_in[7:5], 2))
		else $error("mode");
	chk_drive_top: assert property (w1 && reg_wdata_in[2:1] == 2'h3 |-> ##2 drive_level_out == 2'h2)
		else $error("drive");
	chk_prim_off: assert property (w1 && !reg_wdata_in[4] |-> ##2 !primary_oe_out)
		else $error("primary");
	chk_global_hiz: assert property (w2 && reg_wdata_in[5] |-> ##2 !primary_oe_out && !secondary_oe_out)
		else $error("global hiz");
	chk_green_hiz: assert property (w2 && reg_wdata_in[4] |-> ##2 !green_sync_out_pin_oe_out)
		else $error("green hiz");
	chk_pd_force: assert property (wp && reg_wdata_in[3:1] == 3'h4 |-> ##2 power_down_out [*3])
		else $error("power down");
	chk_fast_pd: assert property (wp && reg_wdata_in[3:1] == 3'h5 |-> ##2 !power_down_out && !primary_oe_out)
		else $error("fast");
	// a write two edges back changes the polarity between the two samples
	chk_field_track: assert property (up_q == 3'h7 && !$past(reg_wr_in, 1) && !$past(reg_wr_in, 2) |->
		(field_out ^ $past(field_out)) == ($past(field_odd_in) ^ $past(field_odd_in, 2))) else $error("field");
	chk_clkgen_src: assert property (up_q == 3'h7 && $past(raw_sync_in) == $past(filt_sync_in) |->
		clkgen_sync_out == $past(raw_sync_in)) else $error("clkgen");
endmodule // opc_regs_assertions
bind opc_output_power_regs opc_regs_assertions chk_i (.*);

// >>> opc_video_sink.sv
/* downstream logic model watching the pixel clock pin.
   assumes pin level and enable come straight from the register group. */
module opc_video_sink (
	input wire logic sys_clk_in,
	input wire logic pclk_in,
	input wire logic pclk_oe_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_q;
	always @(posedge sys_clk_in) if (pclk_oe_in) last_q <= pclk_in;
	// released pin: inverse of last level, so stale data never passes
	assign line_out = pclk_oe_in ? pclk_in : ~last_q;
endmodule // opc_video_sink

// >>> test_output_power_control_regs.sv
/* self-checking bench for the output and power register group.
   assumes design files and opc_video_sink are compiled first. */
module test_output_power_control_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, wr = 0, pin = 1, idl = 0, fld = 1, raw = 1, filt = 0, regen = 0;
	logic [3:0] pck = 4'h0;
	logic [7:0] addr = 8'h1e, wdata = 8'h00;
	wire [7:0] rdata;
	wire pd, m4, m2, md, pclk, fo, cg, sp, po, so, ko, go, line, vo, co;
	wire [2:0] mode;
	wire [1:0] drv, vdrv;
	wire [13:0] obs = {pd, m4, m2, md, drv, po, so, go, ko, pclk, fo, cg, sp};
	int miscompares = 0, n_checks = 0, i;
	logic [7:0] rv [6] = '{8'h30, 8'h94, 8'h05, 8'h20, 8'h32, 8'h00};
	logic [29:0] rows [11] = '{{16'h1fb9, 14'b0_010_00_1111_1_101}, {16'h1fca, 14'b0_001_01_0111_0_101},
		{16'h1f96, 14'b0_100_10_1011_0_101}, {16'h2025, 14'b0_100_10_0010_0_101},
		{16'h2015, 14'b0_100_10_1001_0_101}, {16'h200b, 14'b0_100_10_1011_0_010},
		{16'h2005, 14'b0_100_10_1011_0_101}, {16'h1e38, 14'b1_100_10_0010_0_101},
		{16'h1e39, 14'b1_100_10_0000_0_101}, {16'h1e3a, 14'b0_100_10_0010_0_101},
		{16'h1e30, 14'b0_100_10_1011_0_101}};
	always #25 clk = ~clk;
	opc_output_power_regs dut (.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rdata_out(rdata), .pwrdn_pin_in(pin), .auto_idle_in(idl), .pix_clk_in(pck[3]),
		.pix_clk_p90_in(pck[2]), .pix_clk_x2_in(pck[1]), .pix_clk_half_in(pck[0]), .field_odd_in(fld),
		.raw_sync_in(raw), .filt_sync_in(filt), .regen_sync_in(regen), .power_down_out(pd), .out_mode_out(mode),
		.mode_444_out(m4), .mode_422_out(m2), .mode_ddr_out(md), .drive_level_out(drv), .vsync_drive_out(vdrv),
		.pixel_clock_out_pin_out(pclk), .field_out(fo), .clkgen_sync_out(cg), .syncproc_sync_out(sp),
		.primary_oe_out(po), .secondary_oe_out(so), .pixel_clock_oe_out(ko), .vertical_sync_oe_out(vo),
		.ctrl_pins_oe_out(co), .green_sync_out_pin_oe_out(go));
	opc_video_sink sink (.sys_clk_in(clk), .pclk_in(pclk), .pclk_oe_in(ko), .line_out(line));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	// even counts leave the sources as they were
	task automatic idle_n(input int n);
		repeat (n) begin
			@(negedge clk);
			fld = ~fld;
			filt = ~filt;
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		idle_n(8);
		for (i = 0; i < 6; i++) begin
			@(negedge clk);
			addr = 8'h1e + 8'(i);
			@(negedge clk);
			chk("reset value", rv[i], rdata);
		end
		chk("reset outputs", 14'b0_100_10_1011_0_101, obs);
		chk("vsync drive", 2'h2, vdrv);
		chk("side pins oe", 2'h3, {vo, co});
		for (i = 0; i < 11; i++) begin
			put(rows[i][29:22], rows[i][21:14]);
			repeat (2) @(negedge clk);
			chk("readback", rows[i][21:14], rdata);
			chk("outputs", rows[i][13:0], obs);
			chk("side pins oe", {2{rows[i][4]}}, {vo, co});
		end
		for (i = 0; i < 4; i++) begin
			put(8'h20, {2'(i), 6'h05});
			pck = 4'h8 >> i;
			repeat (2) @(negedge clk);
			chk("clock line", 1'b1, line);
		end
		put(8'h1f, 8'h95);
		repeat (2) @(negedge clk);
		chk("inverted clock", 1'b0, line);
		pin = 0;
		idle_n(8);
		chk("pin low", 1'b1, pd);
		put(8'h1e, 8'h34);
		idle_n(4);
		chk("pin polarity", 1'b0, pd);
		pin = 1;
		idle_n(8);
		chk("pin high", 1'b1, pd);
		put(8'h1e, 8'h30);
		idl = 1;
		idle_n(8);
		chk("auto request", 1'b1, pd);
		put(8'h1e, 8'h20);
		idle_n(4);
		chk("manual mode", 1'b0, pd);
		put(8'h23, 8'hff);
		repeat (2) @(negedge clk);
		chk("unmapped", 8'h00, rdata);
		give_verdict();
	end
endmodule // test_output_power_control_regs
